// ### hw/seep_pkg.sv
// constants shared by the two-wire eeprom target logic
package seep_pkg;
  localparam int unsigned PAGE_W       = 5;
  localparam int unsigned PAGE_BYTES   = 32;
  localparam int unsigned STRAP_W      = 3;
  localparam logic [3:0]  DEV_PREAMBLE = 4'hA;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [3:0]  BIT_END      = 4'h9;
  localparam int unsigned ADDR_W_SMALL = 12;
  localparam int unsigned ADDR_W_LARGE = 13;
  localparam int unsigned PROG_US_FAST = 10000;
  localparam int unsigned PROG_US_SLOW = 20000;
  localparam int unsigned MCLK_HZ      = 10000000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV  = 6'h02,
    ST_AHI  = 6'h04,
    ST_ALO  = 6'h08,
    ST_WR   = 6'h10,
    ST_RD   = 6'h20
  } seep_state_t;
endpackage : seep_pkg

// ### hw/seep_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module seep_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      // idle level, so no false edge follows reset
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : seep_sync

// ### hw/seep_mem.sv
// byte array with one write port and a registered read port
`timescale 1ns/100ps
module seep_mem #(
  parameter int unsigned AW = 12
) (
  input  wire logic          mclk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] cells [0:(2**AW)-1];

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        cells[waddr] <= wdata;
      end
      rdata <= cells[raddr];
    end
  end
endmodule : seep_mem

// ### hw/seep_slave.sv
// two-wire eeprom target: protocol engine, page buffer, program timer
`timescale 1ns/100ps
module seep_slave
  import seep_pkg::*;
#(
  parameter int unsigned ADDR_W  = seep_pkg::ADDR_W_SMALL,
  parameter int unsigned PROG_US = seep_pkg::PROG_US_FAST,
  parameter int unsigned CLK_HZ  = seep_pkg::MCLK_HZ
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        scl,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe,
  input  wire logic [seep_pkg::STRAP_W-1:0] chip_select_straps,
  input  wire logic                        wp,
  output logic                             standby,
  output logic                             busy
);
  import seep_pkg::*;

  localparam int unsigned PROG_CYC = (PROG_US * (CLK_HZ / 1000000) > 0) ?
                                     PROG_US * (CLK_HZ / 1000000) : 1;
  localparam int unsigned TW       = $clog2(PROG_CYC + 1);
  localparam int unsigned HI_W     = ADDR_W - PAGE_W;
  localparam logic [TW-1:0]     PROG_LOAD = TW'(PROG_CYC - 1);
  localparam logic [PAGE_W-1:0] IDX_LAST  = PAGE_W'(PAGE_BYTES - 1);

  // synchronised pins
  logic [STRAP_W+2:0] pins_s;
  logic               scl_s;
  logic               sda_s;
  logic               wp_s;
  logic [STRAP_W-1:0] cs_s;

  // bus pins reset to their pulled-up idle level
  seep_sync #(
    .W       (STRAP_W + 3),
    .RST_VAL ({2'b11, 1'b0, STRAP_W'(0)})
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    ({scl, sda_i, wp, chip_select_straps}),
    .q    (pins_s)
  );

  assign scl_s = pins_s[STRAP_W+2];
  assign sda_s = pins_s[STRAP_W+1];
  assign wp_s  = pins_s[STRAP_W];
  assign cs_s  = pins_s[STRAP_W-1:0];

  logic                scl_q;
  logic                sda_q;
  seep_state_t         state_q;
  logic [3:0]          cnt_q;
  logic [7:0]          shift_q;
  logic [7:0]          tx_q;
  logic [7:0]          ahi_q;
  logic [ADDR_W-1:0]   addr_q;
  logic                oe_q;
  logic                mack_q;
  logic                pend_q;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [7:0]          buf_q [0:PAGE_BYTES-1];
  logic                busy_q;
  logic                commit_q;
  logic [PAGE_W-1:0]   idx_q;
  logic [HI_W-1:0]     page_q;
  logic [TW-1:0]       timer_q;
  logic [7:0]          mem_rdata;

  function automatic logic dev_match_f(input logic [7:0] word,
                                       input logic [STRAP_W-1:0] cs);
    dev_match_f = (word[7:4] == DEV_PREAMBLE) && (word[3:1] == cs);
  endfunction : dev_match_f

  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire active    = (state_q != ST_IDLE);
  wire fall_ack  = active & scl_fall & (cnt_q == BIT_ACK);
  wire fall_end  = active & scl_fall & (cnt_q == BIT_END);
  wire fall_bit  = active & scl_fall & (cnt_q < BIT_ACK) & (state_q == ST_RD);
  wire dev_match = dev_match_f(shift_q, cs_s);
  wire wr_byte   = ~busy_q & ~start_det & ~stop_det & fall_ack & (state_q == ST_WR);
  wire load_rd   = fall_end & ((state_q == ST_DEV & shift_q[0]) |
                               (state_q == ST_RD & mack_q));
  wire [15:0]       word_addr = {ahi_q, shift_q};
  wire [ADDR_W-1:0] new_addr  = word_addr[ADDR_W-1:0];
  wire [PAGE_W-1:0] low_inc   = PAGE_W'(addr_q[PAGE_W-1:0] + 1'b1);
  wire [ADDR_W-1:0] lin_inc   = ADDR_W'(addr_q + 1'b1);
  wire              mem_we    = commit_q & mask_q[idx_q];
  wire [ADDR_W-1:0] mem_waddr = {page_q, idx_q};

  seep_mem #(.AW(ADDR_W)) u_mem (
    .mclk  (mclk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (buf_q[idx_q]),
    .raddr (addr_q),
    .rdata (mem_rdata)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // protocol engine
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      shift_q <= '0;
      tx_q    <= '0;
      ahi_q   <= '0;
      addr_q  <= '0;
      oe_q    <= 1'b0;
      mack_q  <= 1'b0;
      pend_q  <= 1'b0;
    end else if (ce) begin
      if (busy_q) begin
        state_q <= ST_IDLE;
        oe_q    <= 1'b0;
        cnt_q   <= '0;
        pend_q  <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_DEV;
        cnt_q   <= '0;
        oe_q    <= 1'b0;
        pend_q  <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        cnt_q   <= '0;
        oe_q    <= 1'b0;
        pend_q  <= 1'b0;
      end else if (active && scl_rise) begin
        if (cnt_q < BIT_ACK) begin
          shift_q <= {shift_q[6:0], sda_s};
        end
        if (cnt_q == BIT_ACK) begin
          mack_q <= ~sda_s;
        end
        if (cnt_q != BIT_END) begin
          cnt_q <= 4'(cnt_q + 1'b1);
        end
      end else if (fall_bit && cnt_q != 4'h0) begin
        oe_q <= ~tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end else if (fall_ack) begin
        if (state_q == ST_RD) begin
          oe_q <= 1'b0;
        end else if (state_q == ST_DEV) begin
          oe_q <= dev_match;
          if (!dev_match) begin
            state_q <= ST_IDLE;
          end
        end else begin
          oe_q <= 1'b1;
        end
        if (state_q == ST_WR) begin
          addr_q <= {addr_q[ADDR_W-1:PAGE_W], low_inc};
          pend_q <= 1'b1;
        end
      end else if (fall_end) begin
        cnt_q <= '0;
        oe_q  <= 1'b0;
        unique case (state_q)
          ST_DEV: state_q <= shift_q[0] ? ST_RD : ST_AHI;
          ST_AHI: begin
            ahi_q   <= shift_q;
            state_q <= ST_ALO;
          end
          ST_ALO: begin
            addr_q  <= new_addr;
            state_q <= ST_WR;
          end
          ST_WR: state_q <= ST_WR;
          ST_RD: begin
            if (!mack_q) begin
              state_q <= ST_IDLE;
            end
          end
          ST_IDLE: state_q <= ST_IDLE;
          default: state_q <= ST_IDLE;
        endcase
        if (load_rd) begin
          tx_q   <= {mem_rdata[6:0], 1'b0};
          oe_q   <= ~mem_rdata[7];
          addr_q <= lin_inc;
        end
      end
    end
  end

  // page buffer
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= '0;
    end else if (ce) begin
      if (start_det && !busy_q) begin
        mask_q <= '0;
      end else if (wr_byte) begin
        mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && wr_byte) begin
      buf_q[addr_q[PAGE_W-1:0]] <= shift_q;
    end
  end

  // self-timed program cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q   <= 1'b0;
      commit_q <= 1'b0;
      idx_q    <= '0;
      page_q   <= '0;
      timer_q  <= '0;
    end else if (ce) begin
      if (!busy_q) begin
        if (stop_det && pend_q && !wp_s) begin
          busy_q   <= 1'b1;
          commit_q <= 1'b1;
          idx_q    <= '0;
          page_q   <= addr_q[ADDR_W-1:PAGE_W];
          timer_q  <= PROG_LOAD;
        end
      end else begin
        if (commit_q) begin
          idx_q <= PAGE_W'(idx_q + 1'b1);
          if (idx_q == IDX_LAST) begin
            commit_q <= 1'b0;
          end
        end
        if (timer_q == '0) begin
          busy_q <= 1'b0;
        end else begin
          timer_q <= TW'(timer_q - 1'b1);
        end
      end
    end
  end

  assign sda_o   = 1'b0;
  assign sda_oe  = oe_q;
  assign busy    = busy_q;
  assign standby = ~active & ~busy_q;

  AST_BUSY_SILENT: assert property (@(posedge mclk) disable iff (rst)
    busy_q |=> !sda_oe) else $error("sda driven during programming");
  AST_START_NEW: assert property (@(posedge mclk) disable iff (rst)
    (ce && start_det && !busy_q) |=> (state_q == ST_DEV && cnt_q == 4'h0))
    else $error("start did not open a transaction");
  AST_STOP_IDLE: assert property (@(posedge mclk) disable iff (rst)
    (ce && stop_det) |=> (state_q == ST_IDLE && !sda_oe))
    else $error("stop did not return to idle");
  AST_OE_SCL_LOW: assert property (@(posedge mclk) disable iff (rst)
    (ce && $changed(oe_q) && !$past(busy_q) && !$past(start_det) && !$past(stop_det))
      |-> !$past(scl_s)) else $error("sda drive changed while scl high");
  AST_MISMATCH_QUIET: assert property (@(posedge mclk) disable iff (rst)
    (ce && !busy_q && !start_det && !stop_det && fall_ack && state_q == ST_DEV && !dev_match)
      |=> (!sda_oe && state_q == ST_IDLE)) else $error("mismatched address answered");
  AST_MATCH_ACK: assert property (@(posedge mclk) disable iff (rst)
    (ce && !busy_q && !start_det && !stop_det && fall_ack && state_q == ST_DEV && dev_match)
      |=> sda_oe) else $error("matched address not acknowledged");
  AST_WP_BLOCKS: assert property (@(posedge mclk) disable iff (rst)
    (ce && stop_det && wp_s && !busy_q) |=> !busy_q)
    else $error("program started under write protect");
  AST_PROG_START: assert property (@(posedge mclk) disable iff (rst)
    (ce && stop_det && pend_q && !wp_s && !busy_q) |=> (busy_q && commit_q))
    else $error("stop after write did not start programming");
  AST_PAGE_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (ce && wr_byte) |=> (addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W])
      && addr_q[PAGE_W-1:0] == PAGE_W'($past(addr_q[PAGE_W-1:0]) + 1'b1)))
    else $error("write address left its page");
  AST_READ_INC: assert property (@(posedge mclk) disable iff (rst)
    (ce && !busy_q && !start_det && !stop_det && load_rd)
      |=> addr_q == ADDR_W'($past(addr_q) + 1'b1)) else $error("read address not advanced");

  COV_MATCH: cover property (@(posedge mclk) disable iff (rst)
    fall_ack && state_q == ST_DEV && dev_match);
  COV_PROG: cover property (@(posedge mclk) disable iff (rst)
    $rose(busy_q) ##[1:300] mem_we);
  COV_SEQ_READ: cover property (@(posedge mclk) disable iff (rst)
    load_rd && state_q == ST_RD);
endmodule : seep_slave

// ### tb/seep_ctl_model.sv
// two-wire bus controller model: drives scl, pulls sda low
`timescale 1ns/100ps
module seep_ctl_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  // data moves only in the low phase, read back mid high
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    sda_oe = ~b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
  endtask : bit_io
  // long low phase lets a target release its ack first
  task automatic start();
    scl = 1'b0;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
  endtask : start
  task automatic stop();
    scl = 1'b0;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask : stop
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, r);
      if (r === 1'b1) break;
    end
    start();
    stop();
  endtask : recover
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ack_it, r);
  endtask : recv_byte
endmodule : seep_ctl_model

// ### tb/seep_slave_tb_top.sv
// self-checking bench for the two-wire eeprom target
`timescale 1ns/100ps
module seep_slave_tb_top;
  import seep_pkg::*;
  logic       mclk, rst, ce, wp, scl, m_oe, sda_o, sda_oe, standby, busy;
  logic [2:0] straps;
  wire        sda = ~(m_oe | sda_oe);
  int         error_cnt;
  int         compares;
  seep_slave #(.PROG_US(10)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .chip_select_straps(straps), .wp(wp), .standby(standby),
    .busy(busy)
  );
  seep_ctl_model ctl (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_prog();
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge mclk);
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("mismatch %0t program cycle hung", $time);
      end_of_test();
    end
    chk(8'(standby), 8'h01, "standby after program");
  endtask : wait_prog
  task automatic wr(input logic [11:0] a, input int n, input logic [7:0] d);
    logic k;
    logic ok;
    ok = 1'b1;
    ctl.start();
    ctl.send_byte({DEV_PREAMBLE, straps, 1'b0}, k);
    ok &= k;
    ctl.send_byte({4'hF, a[11:8]}, k);
    ok &= k;
    ctl.send_byte(a[7:0], k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      ctl.send_byte(d + 8'(i), k);
      ok &= k;
    end
    chk(8'(ok), 8'h01, "write acks");
    if (n > 0) ctl.stop();
  endtask : wr
  task automatic rd(input logic rnd, input logic [11:0] a, input logic [7:0] e[$]);
    logic       k;
    logic [7:0] b;
    if (rnd) wr(a, 0, 8'h00);
    ctl.start();
    ctl.send_byte({DEV_PREAMBLE, straps, 1'b1}, k);
    chk(8'(k), 8'h01, "read address ack");
    foreach (e[i]) begin
      ctl.recv_byte(i < e.size() - 1, b);
      chk(b, e[i], "read data");
    end
    ctl.stop();
    chk(8'(standby), 8'h01, "standby after read");
  endtask : rd
  task automatic t_reset();
    chk(8'({standby, busy, sda_oe}), 8'h04, "reset state");
    chk(8'(sda_o), 8'h00, "open drain level");
    ctl.recover();
    ce = 1'b0;
    ctl.start();
    chk(8'(standby), 8'h01, "start seen while frozen");
    ctl.stop();
    ce = 1'b1;
  endtask : t_reset
  task automatic t_match();
    logic k;
    for (int c = 0; c < 9; c++) begin
      ctl.start();
      ctl.send_byte(c < 8 ? {DEV_PREAMBLE, 3'(c), 1'b0} : {4'hB, straps, 1'b0}, k);
      chk(8'(standby), 8'(c != 5), "standby after address");
      ctl.stop();
      chk(8'(k), 8'(c == 5), "address match");
    end
    chk(8'(standby), 8'h01, "standby after mismatch");
  endtask : t_match
  task automatic t_write();
    logic k;
    wr(12'hFFF, 1, 8'h5A);
    chk(8'(busy), 8'h01, "program started");
    ctl.start();
    ctl.send_byte({DEV_PREAMBLE, straps, 1'b0}, k);
    chk(8'({k, busy}), 8'h01, "poll refused while busy");
    ctl.stop();
    wait_prog();
    wr(12'h000, 1, 8'hA5);
    wait_prog();
    rd(1'b1, 12'hFFF, {8'h5A, 8'hA5});
    rd(1'b1, 12'hFFF, {8'h5A});
    rd(1'b0, 12'h000, {8'hA5});
  endtask : t_write
  task automatic t_page();
    logic [7:0] e[$];
    for (int o = 0; o < 32; o++) e.push_back(8'h12 + 8'(o));
    wr(12'h81E, 34, 8'h10);
    wait_prog();
    rd(1'b1, 12'h800, e);
  endtask : t_page
  task automatic t_wp();
    wp = 1'b1;
    wr(12'h000, 1, 8'h3C);
    chk(8'(busy), 8'h00, "no program when protected");
    wp = 1'b0;
    rd(1'b1, 12'h000, {8'hA5});
  endtask : t_wp
  initial begin
    rst       = 1'b1;
    ce        = 1'b1;
    wp        = 1'b0;
    straps    = 3'h5;
    error_cnt = 0;
    compares  = 0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (12) @(negedge mclk);
    t_reset();
    t_match();
    t_write();
    t_page();
    t_wp();
    end_of_test();
  end
endmodule : seep_slave_tb_top
